// [common/timer16_pkg.sv]
package timer16_pkg;

  // I/O addresses of the timer registers
  localparam logic [7:0] TIMER_CONTROL_A_ADDR = 8'h80;
  localparam logic [7:0] TIMER_CONTROL_B_ADDR = 8'h81;
  localparam logic [7:0] CAPTURE_LO_ADDR      = 8'h86;
  localparam logic [7:0] CAPTURE_HI_ADDR      = 8'h87;
  localparam logic [7:0] COUNTER_LO_ADDR      = 8'h84;
  localparam logic [7:0] COUNTER_HI_ADDR      = 8'h85;
  localparam logic [7:0] COMPARE_A_LO_ADDR    = 8'h88;
  localparam logic [7:0] COMPARE_A_HI_ADDR    = 8'h89;
  localparam logic [7:0] COMPARE_B_LO_ADDR    = 8'h8A;
  localparam logic [7:0] COMPARE_B_HI_ADDR    = 8'h8B;

  // Field positions in timer_control_a
  localparam int COM_A_POS      = 6;
  localparam int COM_B_POS      = 4;
  localparam int WAVE_LO_POS    = 0;
  // Field position in timer_control_b
  localparam int WAVE_HI_POS    = 3;

  // Reset values and write masks
  localparam logic [7:0]  CONTROL_A_RESET = 8'h00;
  localparam logic [7:0]  CONTROL_B_RESET = 8'h00;
  localparam logic [7:0]  CONTROL_A_MASK  = 8'hF3;
  localparam logic [7:0]  CONTROL_B_MASK  = 8'hDF;
  localparam logic [15:0] VALUE_RESET     = 16'h0000;
  localparam logic [7:0]  LATCH_RESET     = 8'h00;

  // Fixed TOP values
  localparam logic [15:0] TOP_MAX   = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT  = 16'h00FF;
  localparam logic [15:0] TOP_9BIT  = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;

  // Counting family
  typedef enum logic [2:0] {
    FAMILY_NORMAL,
    FAMILY_MATCH_CLEAR,
    FAMILY_FAST,
    FAMILY_PHASE,
    FAMILY_PHASE_FREQ,
    FAMILY_RESERVED
  } family_type;

  // Event that updates the compare buffers or sets the overflow flag
  typedef enum logic [1:0] {
    AT_IMMEDIATE,
    AT_TOP,
    AT_BOTTOM,
    AT_MAX
  } moment_type;

  // TOP source
  typedef enum logic [1:0] {
    TOP_FIXED,
    TOP_COMPARE_A,
    TOP_CAPTURE
  } top_src_type;

  // Pin action on an event
  typedef enum logic [1:0] {
    PIN_KEEP,
    PIN_TOGGLE,
    PIN_CLEAR,
    PIN_SET
  } action_type;

  // Decoded waveform mode
  typedef struct packed {
    family_type  family;
    top_src_type top_src;
    logic [15:0] top_fixed;
    moment_type  update_at;
    moment_type  overflow_at;
  } mode_decode_type;

  // Compare events from the counting datapath
  typedef struct packed {
    logic match_a;
    logic match_b;
    logic bottom;
    logic counting_down;
  } timer_event_type;

endpackage : timer16_pkg

// [src/wave_mode_decode.sv]
`timescale 1ns/10ps
module wave_mode_decode
  import timer16_pkg::*;
(
  input  wire logic [3:0]      waveform_mode_i,
  output mode_decode_type      decode_o
);

  // Table decode of the 4-bit waveform mode
  function automatic mode_decode_type decode_mode(input logic [3:0] m);
    mode_decode_type d;
    d = '{FAMILY_RESERVED, TOP_FIXED, TOP_MAX, AT_IMMEDIATE, AT_MAX};
    case (m)
      4'h0: d = '{FAMILY_NORMAL, TOP_FIXED, TOP_MAX, AT_IMMEDIATE, AT_MAX};
      4'h4: d = '{FAMILY_MATCH_CLEAR, TOP_COMPARE_A, TOP_MAX, AT_IMMEDIATE, AT_MAX};
      4'hC: d = '{FAMILY_MATCH_CLEAR, TOP_CAPTURE, TOP_MAX, AT_IMMEDIATE, AT_MAX};
      4'h1: d = '{FAMILY_PHASE, TOP_FIXED, TOP_8BIT, AT_TOP, AT_BOTTOM};
      4'h2: d = '{FAMILY_PHASE, TOP_FIXED, TOP_9BIT, AT_TOP, AT_BOTTOM};
      4'h3: d = '{FAMILY_PHASE, TOP_FIXED, TOP_10BIT, AT_TOP, AT_BOTTOM};
      4'hA: d = '{FAMILY_PHASE, TOP_CAPTURE, TOP_MAX, AT_TOP, AT_BOTTOM};
      4'hB: d = '{FAMILY_PHASE, TOP_COMPARE_A, TOP_MAX, AT_TOP, AT_BOTTOM};
      4'h8: d = '{FAMILY_PHASE_FREQ, TOP_CAPTURE, TOP_MAX, AT_BOTTOM, AT_BOTTOM};
      4'h9: d = '{FAMILY_PHASE_FREQ, TOP_COMPARE_A, TOP_MAX, AT_BOTTOM, AT_BOTTOM};
      4'h5: d = '{FAMILY_FAST, TOP_FIXED, TOP_8BIT, AT_TOP, AT_TOP};
      4'h6: d = '{FAMILY_FAST, TOP_FIXED, TOP_9BIT, AT_TOP, AT_TOP};
      4'h7: d = '{FAMILY_FAST, TOP_FIXED, TOP_10BIT, AT_TOP, AT_TOP};
      4'hE: d = '{FAMILY_FAST, TOP_CAPTURE, TOP_MAX, AT_TOP, AT_TOP};
      4'hF: d = '{FAMILY_FAST, TOP_COMPARE_A, TOP_MAX, AT_TOP, AT_TOP};
      default: d = '{FAMILY_RESERVED, TOP_FIXED, TOP_MAX, AT_IMMEDIATE, AT_MAX};
    endcase
    return d;
  endfunction : decode_mode

  assign decode_o = decode_mode(waveform_mode_i);

endmodule : wave_mode_decode

// [src/compare_pin_ctrl.sv]
`timescale 1ns/10ps
module compare_pin_ctrl
  import timer16_pkg::*;
#(
  parameter bit IS_CHANNEL_A = 1'b1
) (
  input  wire logic [1:0]      mode_i,
  input  wire family_type      family_i,
  input  wire logic            wave_bit3_i,
  input  wire logic            match_i,
  input  wire logic            at_top_i,
  input  wire logic            bottom_i,
  input  wire logic            counting_down_i,
  output action_type           action_o,
  output logic                 connected_o
);

  wire logic is_pwm;
  wire logic toggle_ok;
  wire logic match_used;

  // PWM families and the code 01 toggle allowance
  assign is_pwm     = (family_i == FAMILY_FAST) || (family_i == FAMILY_PHASE) ||
                      (family_i == FAMILY_PHASE_FREQ);
  assign toggle_ok  = IS_CHANNEL_A && wave_bit3_i;
  // Fast PWM ignores a match at TOP once the upper code bit is set
  assign match_used = match_i && !(family_i == FAMILY_FAST && mode_i[1] && at_top_i);

  // Pin override whenever either bit is set, unless code 01 disconnects
  assign connected_o = (mode_i != 2'b00) &&
                       !(is_pwm && mode_i == 2'b01 && !toggle_ok);

  // Action per family and code
  always_comb begin
    action_o = PIN_KEEP;
    case (family_i)
      FAMILY_NORMAL, FAMILY_MATCH_CLEAR: begin
        if (match_i) begin
          action_o = action_type'(mode_i);
        end
      end
      FAMILY_FAST: begin
        if (mode_i == 2'b01) begin
          action_o = (match_i && toggle_ok) ? PIN_TOGGLE : PIN_KEEP;
        end else if (mode_i != 2'b00 && match_used) begin
          action_o = mode_i[0] ? PIN_SET : PIN_CLEAR;
        end else if (mode_i != 2'b00 && bottom_i) begin
          action_o = mode_i[0] ? PIN_CLEAR : PIN_SET;
        end
      end
      FAMILY_PHASE, FAMILY_PHASE_FREQ: begin
        if (mode_i == 2'b01) begin
          action_o = (match_i && toggle_ok) ? PIN_TOGGLE : PIN_KEEP;
        end else if (mode_i != 2'b00 && match_i) begin
          action_o = (mode_i[0] ^ counting_down_i) ? PIN_SET : PIN_CLEAR;
        end
      end
      default: action_o = PIN_KEEP;
    endcase
  end

endmodule : compare_pin_ctrl

// [src/timer16_access.sv]
`timescale 1ns/10ps
// Summary of operation
// - One 8-bit high-byte latch serves all four 16-bit timer registers.
// - Low-byte write loads latched high byte and new low byte together.
// - Counter or capture low-byte read copies that register's high byte into the latch.
// - Compare A and B high bytes read directly, latch untouched.
// - Latch persists after low-byte writes, allowing reuse of one high byte.
// - Nonzero compare output mode overrides the pin's port function.
// - Pin driver enabled only when its direction bit is set.
// - Non-PWM codes: disconnect, toggle, clear, set on compare match.
// - PWM code 01 disconnects unless mode bit3; then A toggles, B reserved.
// - Fast PWM code 10 clear on match set at BOTTOM; 11 opposite.
// - Fast PWM compare equal TOP with upper bit set ignores match.
// - Dual-slope code 10 clears on up match, sets on down; 11 opposite.
// - Waveform mode low bits at control A 1:0, upper bits in control B.
// - Normal and clear-on-match modes: TOP, immediate update, overflow at MAX.
// - Phase correct modes: fixed or register TOP, update TOP, overflow BOTTOM.
// - Phase and frequency correct: register TOP, update and overflow at BOTTOM.
// - Fast PWM: fixed or register TOP, update and overflow at TOP.
// - Upper waveform mode bits sit at control B bits 4:3.
module timer16_access
  import timer16_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            rst_b_i,
  // CPU I/O access
  input  wire logic [7:0]      io_addr_i,
  input  wire logic [7:0]      io_wdata_i,
  input  wire logic            io_write_i,
  input  wire logic            io_read_i,
  output logic [7:0]           io_rdata_o,
  // Datapath side
  input  wire logic [15:0]     counter_now_i,
  input  wire logic            capture_load_i,
  input  wire logic [15:0]     capture_now_i,
  input  wire timer_event_type event_i,
  input  wire logic            dir_a_i,
  input  wire logic            dir_b_i,
  output logic [15:0]          counter_load_value_o,
  output logic                 counter_load_o,
  output logic [15:0]          compare_a_value_o,
  output logic [15:0]          compare_b_value_o,
  output logic [15:0]          capture_value_o,
  output logic [15:0]          top_value_o,
  output logic [3:0]           waveform_mode_o,
  output logic [1:0]           update_at_o,
  output logic [1:0]           overflow_at_o,
  output logic                 pin_a_o,
  output logic                 pin_a_oe_o,
  output logic                 pin_a_override_o,
  output logic                 pin_b_o,
  output logic                 pin_b_oe_o,
  output logic                 pin_b_override_o
);

  logic [7:0]      latch_q;
  logic [7:0]      latch_d;
  logic [7:0]      control_a_q;
  logic [7:0]      control_b_q;
  logic [15:0]     compare_a_q;
  logic [15:0]     compare_b_q;
  logic [15:0]     capture_q;
  logic [15:0]     load_value_q;
  logic            load_q;
  logic [7:0]      rdata_q;
  logic [7:0]      rdata_d;
  logic            pin_a_q;
  logic            pin_b_q;
  logic            oe_a_q;
  logic            oe_b_q;
  logic            ovr_a_q;
  logic            ovr_b_q;
  logic [15:0]     top_q;
  logic [3:0]      mode_q;
  logic [1:0]      upd_q;
  logic [1:0]      ovf_q;

  wire logic       wr_ctl_a;
  wire logic       wr_ctl_b;
  wire logic       wr_cnt_lo;
  wire logic       wr_cmp_a_lo;
  wire logic       wr_cmp_b_lo;
  wire logic       wr_cap_lo;
  wire logic       wr_any_hi;
  wire logic       rd_cnt_lo;
  wire logic       rd_cap_lo;
  wire logic [15:0] write_word;
  wire logic [3:0] wave_mode;
  wire mode_decode_type decode;
  wire logic [15:0] top_value;
  wire logic       at_top;
  wire logic       at_top_a;
  wire logic       at_top_b;
  wire action_type act_a;
  wire action_type act_b;
  wire logic       conn_a;
  wire logic       conn_b;

  // Address match helper
  function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] r);
    return strobe && (a == r);
  endfunction : hit

  // Apply a pin action
  function automatic logic apply(input action_type act, input logic cur);
    logic r;
    r = cur;
    case (act)
      PIN_TOGGLE: r = !cur;
      PIN_CLEAR:  r = 1'b0;
      PIN_SET:    r = 1'b1;
      default:    r = cur;
    endcase
    return r;
  endfunction : apply

  // Write and read decode
  assign wr_ctl_a    = hit(io_write_i, io_addr_i, TIMER_CONTROL_A_ADDR);
  assign wr_ctl_b    = hit(io_write_i, io_addr_i, TIMER_CONTROL_B_ADDR);
  assign wr_cnt_lo   = hit(io_write_i, io_addr_i, COUNTER_LO_ADDR);
  assign wr_cmp_a_lo = hit(io_write_i, io_addr_i, COMPARE_A_LO_ADDR);
  assign wr_cmp_b_lo = hit(io_write_i, io_addr_i, COMPARE_B_LO_ADDR);
  assign wr_cap_lo   = hit(io_write_i, io_addr_i, CAPTURE_LO_ADDR);
  assign wr_any_hi   = hit(io_write_i, io_addr_i, COUNTER_HI_ADDR) ||
                       hit(io_write_i, io_addr_i, COMPARE_A_HI_ADDR) ||
                       hit(io_write_i, io_addr_i, COMPARE_B_HI_ADDR) ||
                       hit(io_write_i, io_addr_i, CAPTURE_HI_ADDR);
  assign rd_cnt_lo   = hit(io_read_i, io_addr_i, COUNTER_LO_ADDR);
  assign rd_cap_lo   = hit(io_read_i, io_addr_i, CAPTURE_LO_ADDR);
  assign write_word  = {latch_q, io_wdata_i};

  // Shared latch: high-byte writes and counter or capture low-byte reads load it, else it holds
  always_comb begin
    latch_d = latch_q;
    if (wr_any_hi) begin
      latch_d = io_wdata_i;
    end else if (rd_cnt_lo) begin
      latch_d = counter_now_i[15:8];
    end else if (rd_cap_lo) begin
      latch_d = capture_q[15:8];
    end
  end

  // Read data mux; compare high bytes bypass the latch
  always_comb begin
    rdata_d = 8'h00;
    case (io_addr_i)
      TIMER_CONTROL_A_ADDR: rdata_d = control_a_q & CONTROL_A_MASK;
      TIMER_CONTROL_B_ADDR: rdata_d = control_b_q & CONTROL_B_MASK;
      COUNTER_LO_ADDR:      rdata_d = counter_now_i[7:0];
      COUNTER_HI_ADDR:      rdata_d = latch_q;
      CAPTURE_LO_ADDR:      rdata_d = capture_q[7:0];
      CAPTURE_HI_ADDR:      rdata_d = latch_q;
      COMPARE_A_LO_ADDR:    rdata_d = compare_a_q[7:0];
      COMPARE_A_HI_ADDR:    rdata_d = compare_a_q[15:8];
      COMPARE_B_LO_ADDR:    rdata_d = compare_b_q[7:0];
      COMPARE_B_HI_ADDR:    rdata_d = compare_b_q[15:8];
      default:              rdata_d = 8'h00;
    endcase
  end

  // Mode assembly and TOP selection
  assign wave_mode = {control_b_q[WAVE_HI_POS +: 2], control_a_q[WAVE_LO_POS +: 2]};
  assign top_value = (decode.top_src == TOP_COMPARE_A) ? compare_a_q :
                     (decode.top_src == TOP_CAPTURE)   ? capture_q : decode.top_fixed;
  assign at_top    = (counter_now_i == top_value);
  assign at_top_a  = at_top && (compare_a_q == top_value);
  assign at_top_b  = at_top && (compare_b_q == top_value);

  wave_mode_decode u_decode (
    .waveform_mode_i (wave_mode),
    .decode_o        (decode)
  );

  compare_pin_ctrl #(.IS_CHANNEL_A(1'b1)) u_pin_a (
    .mode_i          (control_a_q[COM_A_POS +: 2]),
    .family_i        (decode.family),
    .wave_bit3_i     (wave_mode[3]),
    .match_i         (event_i.match_a),
    .at_top_i        (at_top_a),
    .bottom_i        (event_i.bottom),
    .counting_down_i (event_i.counting_down),
    .action_o        (act_a),
    .connected_o     (conn_a)
  );

  compare_pin_ctrl #(.IS_CHANNEL_A(1'b0)) u_pin_b (
    .mode_i          (control_a_q[COM_B_POS +: 2]),
    .family_i        (decode.family),
    .wave_bit3_i     (wave_mode[3]),
    .match_i         (event_i.match_b),
    .at_top_i        (at_top_b),
    .bottom_i        (event_i.bottom),
    .counting_down_i (event_i.counting_down),
    .action_o        (act_b),
    .connected_o     (conn_b)
  );

  // CPU-facing registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latch_q     <= LATCH_RESET;
      control_a_q <= CONTROL_A_RESET;
      control_b_q <= CONTROL_B_RESET;
      rdata_q     <= 8'h00;
    end else begin
      latch_q <= latch_d;
      if (io_read_i) begin
        rdata_q <= rdata_d;
      end
      if (wr_ctl_a) begin
        control_a_q <= io_wdata_i & CONTROL_A_MASK;
      end
      if (wr_ctl_b) begin
        control_b_q <= io_wdata_i & CONTROL_B_MASK;
      end
    end
  end

  // 16-bit value registers, written as one word
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      compare_a_q  <= VALUE_RESET;
      compare_b_q  <= VALUE_RESET;
      capture_q    <= VALUE_RESET;
      load_value_q <= VALUE_RESET;
      load_q       <= 1'b0;
    end else begin
      load_q <= wr_cnt_lo;
      if (wr_cnt_lo) begin
        load_value_q <= write_word;
      end
      if (wr_cmp_a_lo) begin
        compare_a_q <= write_word;
      end
      if (wr_cmp_b_lo) begin
        compare_b_q <= write_word;
      end
      if (wr_cap_lo) begin
        capture_q <= write_word;
      end else if (capture_load_i) begin
        capture_q <= capture_now_i;
      end
    end
  end

  // Compare output pins and decoded mode outputs
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
      oe_a_q  <= 1'b0;
      oe_b_q  <= 1'b0;
      ovr_a_q <= 1'b0;
      ovr_b_q <= 1'b0;
      top_q   <= TOP_MAX;
      mode_q  <= 4'h0;
      upd_q   <= 2'h0;
      ovf_q   <= 2'h0;
    end else begin
      pin_a_q <= apply(act_a, pin_a_q);
      pin_b_q <= apply(act_b, pin_b_q);
      ovr_a_q <= conn_a;
      ovr_b_q <= conn_b;
      oe_a_q  <= conn_a && dir_a_i;
      oe_b_q  <= conn_b && dir_b_i;
      top_q   <= top_value;
      mode_q  <= wave_mode;
      upd_q   <= decode.update_at;
      ovf_q   <= decode.overflow_at;
    end
  end

  // Output drive straight from flip-flops
  assign io_rdata_o           = rdata_q;
  assign counter_load_value_o = load_value_q;
  assign counter_load_o       = load_q;
  assign compare_a_value_o    = compare_a_q;
  assign compare_b_value_o    = compare_b_q;
  assign capture_value_o      = capture_q;
  assign top_value_o          = top_q;
  assign waveform_mode_o      = mode_q;
  assign update_at_o          = upd_q;
  assign overflow_at_o        = ovf_q;
  assign pin_a_o              = pin_a_q;
  assign pin_a_oe_o           = oe_a_q;
  assign pin_a_override_o     = ovr_a_q;
  assign pin_b_o              = pin_b_q;
  assign pin_b_oe_o           = oe_b_q;
  assign pin_b_override_o     = ovr_b_q;

  // Checks
  sequence hi_write_s;
    wr_any_hi;
  endsequence

  sequence reuse_write_s;
    wr_cmp_a_lo ##1 !(wr_any_hi || rd_cnt_lo || rd_cap_lo) ##1 wr_cmp_b_lo;
  endsequence

  low_write_load_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_cmp_a_lo |=> compare_a_q == {$past(latch_q), $past(io_wdata_i)})
    else $error("compare A not loaded as one word");

  hi_then_low_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    hi_write_s ##1 !(wr_any_hi || rd_cnt_lo || rd_cap_lo) ##1 reuse_write_s
      |=> compare_b_q[15:8] == $past(io_wdata_i, 5))
    else $error("latched high byte not used");

  low_read_latch_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_cnt_lo && !wr_any_hi |=> latch_q == $past(counter_now_i[15:8]))
    else $error("low read did not capture high byte");

  cap_read_latch_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_cap_lo && !wr_any_hi |=> latch_q == $past(capture_q[15:8]))
    else $error("capture low read did not capture high byte");

  cmp_read_bypass_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    io_read_i && io_addr_i == COMPARE_B_HI_ADDR |=>
      io_rdata_o == $past(compare_b_q[15:8]) && $stable(latch_q))
    else $error("compare high read used latch");

  latch_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !wr_any_hi && !rd_cnt_lo && !rd_cap_lo |=> $stable(latch_q))
    else $error("latch changed without cause");

  reserved_zero_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    control_a_q[3:2] == 2'b00)
    else $error("reserved control bits set");

  driver_dir_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    pin_a_oe_o |-> $past(dir_a_i) && pin_a_override_o)
    else $error("driver on without direction");

  mode_form_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ##1 waveform_mode_o == {$past(control_b_q[4:3]), $past(control_a_q[1:0])})
    else $error("waveform mode misassembled");

  match_toggle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    decode.family == FAMILY_NORMAL && control_a_q[7:6] == 2'b01 && event_i.match_a
      |=> pin_a_o != $past(pin_a_o))
    else $error("toggle on match missing");

endmodule : timer16_access

// [testbench/cpu_model.sv]
`timescale 1ns/10ps
module cpu_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] io_rdata_i,
  output logic      [7:0] io_addr_o,
  output logic      [7:0] io_wdata_o,
  output logic            io_write_o,
  output logic            io_read_o
);
  // Idle bus at time zero
  initial begin
    io_addr_o = 8'h00;
    io_wdata_o = 8'h00;
    io_write_o = 1'b0;
    io_read_o = 1'b0;
  end

  // Byte write, held until the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_addr_o <= a;
    io_wdata_o <= d;
    io_write_o <= 1'b1;
    @(posedge clk_i);
    io_write_o <= 1'b0;
    io_wdata_o <= ~d;
    @(posedge clk_i);
  endtask : wr

  // Byte read, data taken once it has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    io_addr_o <= a;
    io_read_o <= 1'b1;
    @(posedge clk_i);
    io_read_o <= 1'b0;
    @(posedge clk_i);
    d = io_rdata_i;
  endtask : rd

  // High byte first unless reuse is set, then the low byte, with nothing between
  task automatic wr16(input logic [7:0] lo, input logic [15:0] v, input logic reuse);
    if (!reuse) begin
      wr(lo + 8'h01, v[15:8]);
    end
    wr(lo, v[7:0]);
  endtask : wr16

  // Low byte first, both bytes back to back with nothing between
  task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 8'h01, v[15:8]);
  endtask : rd16
endmodule : cpu_model

// [testbench/timer16_access_test.sv]
`timescale 1ns/10ps
module timer16_access_test;
  import timer16_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [7:0]  addr, wdata, rdata, r;
  logic        wr_en, rd_en, cap_load, dir_a, dir_b, load_o, ovr_a, ovr_b, oe_a, oe_b;
  logic        pwm, ea, eb, pa, pb, pin_a, pin_b;
  logic [1:0]  ca, cb, upd_o, ovf_o;
  logic [3:0]  wm_o, ev, e;
  logic [15:0] cnt_now, cap_now, load_v, load_seen, ca_o, cb_o, cap_o, top_o, v, w, t;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          m_a, m_b, m_cap;
  // Update and overflow moment per mode, one nibble each
  localparam logic [63:0] MOMENTS = 64'h5503_66AA_5553_6663;

  cpu_model cpu_model_i (.clk_i(clk_i), .io_rdata_i(rdata), .io_addr_o(addr),
    .io_wdata_o(wdata), .io_write_o(wr_en), .io_read_o(rd_en));

  timer16_access timer16_access_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .io_addr_i(addr),
    .io_wdata_i(wdata), .io_write_i(wr_en), .io_read_i(rd_en), .io_rdata_o(rdata),
    .counter_now_i(cnt_now), .capture_load_i(cap_load), .capture_now_i(cap_now),
    .event_i(ev), .dir_a_i(dir_a), .dir_b_i(dir_b), .counter_load_value_o(load_v),
    .counter_load_o(load_o), .compare_a_value_o(ca_o), .compare_b_value_o(cb_o),
    .capture_value_o(cap_o), .top_value_o(top_o), .waveform_mode_o(wm_o),
    .update_at_o(upd_o), .overflow_at_o(ovf_o), .pin_a_o(pin_a), .pin_a_oe_o(oe_a),
    .pin_a_override_o(ovr_a), .pin_b_o(pin_b), .pin_b_oe_o(oe_b), .pin_b_override_o(ovr_b));

  always #2 clk_i = ~clk_i;

  // Counter load capture and hang limit
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (load_o === 1'b1) load_seen <= load_v;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    cpu_model_i.rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask : rdc

  // Expected compare output after one event cycle
  function automatic logic pin_model(input logic cur, input logic [1:0] c, input int m,
                                     input logic a, input logic [3:0] ev_in, input logic ign);
    logic mt;
    mt = a ? ev_in[3] : ev_in[2];
    if (m inside {0, 4, 12}) begin
      return (!mt || c == 2'b00) ? cur : (c == 2'b01) ? !cur : c[0];
    end else if (c == 2'b01) begin
      return (mt && a && m[3]) ? !cur : cur;
    end else if (c == 2'b00) begin
      return cur;
    end else if (m inside {5, 6, 7, 14, 15}) begin
      return (mt && !ign) ? c[0] : ev_in[1] ? !c[0] : cur;
    end
    return mt ? (c[0] ^ ev_in[0]) : cur;
  endfunction : pin_model

  task automatic complete_run();
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    cap_load = 1'b0;
    cap_now = 16'h0000;
    cnt_now = 16'h0000;
    dir_a = 1'b0;
    dir_b = 1'b0;
    load_seen = 16'h0000;
    ev = 4'h0;
    pa = 1'b0;
    pb = 1'b0;
    void'($urandom(32'h05dbad6c));
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    // Reset state, unmapped place, reserved bits
    rdc(TIMER_CONTROL_A_ADDR, 8'h00);
    chk(top_o, 16'hFFFF);
    r = 8'($urandom);
    cpu_model_i.wr(8'h83, r);
    rdc(8'h83, 8'h00);
    cpu_model_i.wr(TIMER_CONTROL_A_ADDR, r);
    rdc(TIMER_CONTROL_A_ADDR, r & 8'hF3);
    // One high byte shared by four low-byte writes
    v = 16'($urandom);
    w = 16'($urandom);
    m_a = v;
    m_b = {v[15:8], w[7:0]};
    m_cap = {v[15:8], w[15:8]};
    cpu_model_i.wr16(COMPARE_A_LO_ADDR, v, 1'b0);
    cpu_model_i.wr16(COMPARE_B_LO_ADDR, 16'(m_b), 1'b1);
    cpu_model_i.wr16(CAPTURE_LO_ADDR, 16'(m_cap), 1'b1);
    cpu_model_i.wr16(COUNTER_LO_ADDR, {v[15:8], ~v[7:0]}, 1'b1);
    repeat (2) @(posedge clk_i);
    chk(ca_o, 16'(m_a));
    chk(cb_o, 16'(m_b));
    chk(cap_o, 16'(m_cap));
    chk(load_seen, {v[15:8], ~v[7:0]});
    // Low read freezes the high byte; compare high read goes around it
    t = 16'($urandom);
    cnt_now <= t;
    rdc(COUNTER_LO_ADDR, t[7:0]);
    cnt_now <= ~t;
    rdc(COMPARE_B_HI_ADDR, v[15:8]);
    rdc(COUNTER_HI_ADDR, t[15:8]);
    // Hardware capture then a two-byte read
    m_cap = w ^ 16'hA5C3;
    cap_now <= w ^ 16'hA5C3;
    cap_load <= 1'b1;
    @(posedge clk_i);
    cap_load <= 1'b0;
    @(posedge clk_i);
    cpu_model_i.rd16(CAPTURE_LO_ADDR, v);
    chk(v, 16'(m_cap));
    // Every defined waveform mode with random output codes, except code 01 fixed on A in mode 0
    for (int m = 0; m < 16; m++) begin
      if (m == 13) continue;
      ca = (m == 0) ? 2'b01 : 2'($urandom);
      cb = 2'($urandom);
      dir_a <= 1'($urandom);
      dir_b <= 1'($urandom);
      cpu_model_i.wr(TIMER_CONTROL_A_ADDR, {ca, cb, 2'b00, 2'(m)});
      cpu_model_i.wr(TIMER_CONTROL_B_ADDR, {3'b000, 2'(m >> 2), 3'b000});
      repeat (3) @(posedge clk_i);
      case (m)
        0: t = 16'hFFFF;
        1, 5: t = 16'h00FF;
        2, 6: t = 16'h01FF;
        3, 7: t = 16'h03FF;
        4, 9, 11, 15: t = 16'(m_a);
        default: t = 16'(m_cap);
      endcase
      pwm = !(m inside {0, 4, 12});
      ea = (ca != 2'b00) && !(pwm && ca == 2'b01 && !m[3]);
      eb = (cb != 2'b00) && !(pwm && cb == 2'b01);
      chk({12'h000, wm_o}, 16'(m));
      chk(16'({upd_o, ovf_o}), 16'(MOMENTS[m*4 +: 4]));
      chk(top_o, t);
      chk({14'h0000, ovr_a, ovr_b}, {14'h0000, ea, eb});
      chk({14'h0000, oe_a, oe_b}, {14'h0000, ea & dir_a, eb & dir_b});
      // One event cycle with the counter at TOP, against the pin model
      e = 4'($urandom) | 4'h8;
      pa = pin_model(pa, ca, m, 1'b1, e, ca[1] && (16'(m_a) == t));
      pb = pin_model(pb, cb, m, 1'b0, e, cb[1] && (16'(m_b) == t));
      ev <= e;
      cnt_now <= t;
      @(posedge clk_i);
      ev <= 4'h0;
      @(posedge clk_i);
      chk(16'({pin_a, pin_b}), 16'({pa, pb}));
    end
    complete_run();
  end
endmodule : timer16_access_test
